//--- shared/plf_cfg.svh
// Offsets, field positions, reset values and decode constants of the loop-filter slice.
// Assumes inclusion by bare name from the package and the register module.
`ifndef PLF_CFG_SVH
`define PLF_CFG_SVH
`define PLF_IDX_CAP_ONE 8'h44
`define PLF_IDX_RES_THREE 8'h45
`define PLF_IDX_CAP_THREE 8'h46
`define PLF_IDX_CTRL_ZERO 8'h47
`define PLF_ADDR_W 12
`define PLF_CAP_LSB 0
`define PLF_MODE_BIT 0
`define PLF_RES_LSB 1
`define PLF_PDIV_LSB 2
`define PLF_RST_CAP_ONE 3'h0
`define PLF_RST_RES_THREE 6'h00
`define PLF_RST_MODE 1'h0
`define PLF_RST_CAP_THREE 3'h0
`define PLF_RST_PDIV 3'h7
`define PLF_C1_BASE_PF 9'h005
`define PLF_C1_STEP_PF 9'h032
`define PLF_C3_STEP_PF 6'h05
`define PLF_PDIV_MIN 4'h2
`endif

//--- shared/plf_pkg.sv
// Types of the loop-filter slice: state record and register selector.
// Assumes plf_cfg.svh is on the include path.
`include "plf_cfg.svh"
package plf_pkg;
  typedef enum logic [4:0] {
    PLF_SEL_NONE = 5'h01,
    PLF_SEL_C1 = 5'h02,
    PLF_SEL_R3 = 5'h04,
    PLF_SEL_C3 = 5'h08,
    PLF_SEL_P2 = 5'h10
  } plf_sel_e;
  typedef struct packed {
    logic [2:0] cap_one;
    logic [5:0] res_three;
    logic mode_sel;
    logic [2:0] cap_three;
    logic [2:0] post_div;
    logic [8:0] cap_one_pf;
    logic [10:0] res_three_ohm;
    logic res_three_known;
    logic [5:0] cap_three_pf;
    logic [3:0] post_div_ratio;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } plf_state_s;
endpackage : plf_pkg

//--- rtl/plf_regs.sv
// Loop-filter configuration registers of the first synthesizer and
// post-divider register of the second, reached over APB.
// Assumes an APB master on pclk and a nonvolatile loader on pclk.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "plf_cfg.svh"
module plf_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`PLF_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic nv_load,
  input wire logic [2:0] nv_cap_one,
  input wire logic [5:0] nv_res_three,
  input wire logic nv_mode_sel,
  input wire logic [2:0] nv_cap_three,
  input wire logic [2:0] nv_post_div,
  output logic [2:0] first_loop_cap_one_code,
  output logic [5:0] first_loop_res_three_code,
  output logic first_loop_filter_mode_sel,
  output logic [2:0] first_loop_cap_three_code,
  output logic [2:0] second_synth_post_div_code,
  output logic [8:0] cap_one_pf,
  output logic [10:0] res_three_ohm,
  output logic res_three_known,
  output logic [5:0] cap_three_pf,
  output logic [3:0] post_div_ratio
);
  plf_pkg::plf_state_s s_q;
  plf_pkg::plf_state_s s_d;
  plf_pkg::plf_sel_e sel;

  // Word address to register
  function automatic plf_pkg::plf_sel_e decode_addr(input logic [`PLF_ADDR_W-1:0] a);
    logic [`PLF_ADDR_W-1:0] c1;
    logic [`PLF_ADDR_W-1:0] r3;
    logic [`PLF_ADDR_W-1:0] c3;
    logic [`PLF_ADDR_W-1:0] p2;
    c1 = {2'h0, `PLF_IDX_CAP_ONE, 2'h0};
    r3 = {2'h0, `PLF_IDX_RES_THREE, 2'h0};
    c3 = {2'h0, `PLF_IDX_CAP_THREE, 2'h0};
    p2 = {2'h0, `PLF_IDX_CTRL_ZERO, 2'h0};
    if (a == c1) begin
      decode_addr = plf_pkg::PLF_SEL_C1;
    end else if (a == r3) begin
      decode_addr = plf_pkg::PLF_SEL_R3;
    end else if (a == c3) begin
      decode_addr = plf_pkg::PLF_SEL_C3;
    end else if (a == p2) begin
      decode_addr = plf_pkg::PLF_SEL_P2;
    end else begin
      decode_addr = plf_pkg::PLF_SEL_NONE;
    end
  endfunction : decode_addr

  // Resistor code to ohms; unlisted codes flagged unknown
  function automatic logic [11:0] res_ohm(input logic [5:0] code);
    case (code)
      6'h00: res_ohm = {1'b1, 11'h012};
      6'h02: res_ohm = {1'b1, 11'h13e};
      6'h04: res_ohm = {1'b1, 11'h206};
      6'h08: res_ohm = {1'b1, 11'h2cd};
      6'h10: res_ohm = {1'b1, 11'h356};
      6'h20: res_ohm = {1'b1, 11'h676};
      default: res_ohm = {1'b0, 11'h000};
    endcase
  endfunction : res_ohm

  always_comb begin
    logic [11:0] r;
    logic wr;
    r = 12'h000;
    wr = 1'b0;
    s_d = s_q;
    sel = decode_addr(paddr);
    // Zero-wait APB: ready in the first access cycle
    s_d.pready = psel & ~penable;
    s_d.pslverr = psel & ~penable & (sel == plf_pkg::PLF_SEL_NONE);
    if (psel & ~penable) begin
      s_d.prdata = 32'h0000_0000;
      case (sel)
        plf_pkg::PLF_SEL_C1: s_d.prdata[2:0] = s_q.cap_one;
        plf_pkg::PLF_SEL_R3: s_d.prdata[6:0] = {s_q.res_three, s_q.mode_sel};
        plf_pkg::PLF_SEL_C3: s_d.prdata[2:0] = s_q.cap_three;
        plf_pkg::PLF_SEL_P2: s_d.prdata[4:2] = s_q.post_div;
        default: s_d.prdata = 32'h0000_0000;
      endcase
    end
    // Startup image from the nonvolatile store
    if (nv_load) begin
      s_d.cap_one = nv_cap_one;
      s_d.res_three = nv_res_three;
      s_d.mode_sel = nv_mode_sel;
      s_d.cap_three = nv_cap_three;
      s_d.post_div = nv_post_div;
    end
    // Software write wins over a same-cycle load
    wr = psel & penable & s_q.pready & pwrite & pstrb[0];
    if (wr) begin
      case (sel)
        plf_pkg::PLF_SEL_C1: s_d.cap_one = pwdata[`PLF_CAP_LSB +: 3];
        plf_pkg::PLF_SEL_R3: begin
          s_d.res_three = pwdata[`PLF_RES_LSB +: 6];
          s_d.mode_sel = pwdata[`PLF_MODE_BIT];
        end
        plf_pkg::PLF_SEL_C3: s_d.cap_three = pwdata[`PLF_CAP_LSB +: 3];
        plf_pkg::PLF_SEL_P2: s_d.post_div = pwdata[`PLF_PDIV_LSB +: 3];
        default: s_d.cap_one = s_d.cap_one;
      endcase
    end
    // Decoded component values follow the stored codes
    s_d.cap_one_pf = `PLF_C1_BASE_PF
        + 9'(`PLF_C1_STEP_PF * {6'h00, s_q.cap_one});
    r = res_ohm(s_q.res_three);
    s_d.res_three_ohm = r[10:0];
    s_d.res_three_known = r[11];
    s_d.cap_three_pf = 6'(`PLF_C3_STEP_PF * {3'h0, s_q.cap_three});
    if (s_q.post_div < 3'h2) begin
      s_d.post_div_ratio = `PLF_PDIV_MIN;
    end else begin
      s_d.post_div_ratio = {1'b0, s_q.post_div} + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '{cap_one: `PLF_RST_CAP_ONE, res_three: `PLF_RST_RES_THREE,
               mode_sel: `PLF_RST_MODE, cap_three: `PLF_RST_CAP_THREE,
               post_div: `PLF_RST_PDIV, cap_one_pf: `PLF_C1_BASE_PF,
               res_three_ohm: 11'h012, res_three_known: 1'b1,
               cap_three_pf: 6'h00, post_div_ratio: 4'h8,
               pready: 1'b0, pslverr: 1'b0, prdata: 32'h0000_0000};
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign first_loop_cap_one_code = s_q.cap_one;
  assign first_loop_res_three_code = s_q.res_three;
  assign first_loop_filter_mode_sel = s_q.mode_sel;
  assign first_loop_cap_three_code = s_q.cap_three;
  assign second_synth_post_div_code = s_q.post_div;
  assign cap_one_pf = s_q.cap_one_pf;
  assign res_three_ohm = s_q.res_three_ohm;
  assign res_three_known = s_q.res_three_known;
  assign cap_three_pf = s_q.cap_three_pf;
  assign post_div_ratio = s_q.post_div_ratio;

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence apb_write_to(logic [`PLF_ADDR_W-1:0] a);
    psel && penable && pready && pwrite && pstrb[0] && paddr == a;
  endsequence

  a_c1_write_stored: assert property (
    apb_write_to({2'h0, `PLF_IDX_CAP_ONE, 2'h0}) |=>
      first_loop_cap_one_code == $past(pwdata[2:0]))
    else $error("c1 code not stored");

  a_c1_value_pf: assert property (
    ##1 cap_one_pf == 9'(9'd5 + 9'd50 * $past(first_loop_cap_one_code)))
    else $error("c1 capacitance wrong");

  a_r3_write_fields: assert property (
    apb_write_to({2'h0, `PLF_IDX_RES_THREE, 2'h0}) |=>
      first_loop_res_three_code == $past(pwdata[6:1])
      && first_loop_filter_mode_sel == $past(pwdata[0]))
    else $error("r3 fields not stored");

  a_r3_ohm_table: assert property (
    first_loop_res_three_code == 6'h20 && $stable(first_loop_res_three_code)
      |=> res_three_ohm == 11'd1654 && res_three_known)
    else $error("r3 resistance wrong");

  a_c3_value_pf: assert property (
    ##1 cap_three_pf == 6'(6'd5 * $past(first_loop_cap_three_code)))
    else $error("c3 capacitance wrong");

  a_pdiv_write_stored: assert property (
    apb_write_to({2'h0, `PLF_IDX_CTRL_ZERO, 2'h0}) |=>
      second_synth_post_div_code == $past(pwdata[4:2]))
    else $error("post divider code not stored");

  a_pdiv_ratio_map: assert property (
    second_synth_post_div_code <= 3'h3 |=> post_div_ratio
      == (($past(second_synth_post_div_code) == 3'h3) ? 4'd4
      : ($past(second_synth_post_div_code) == 3'h2) ? 4'd3 : 4'd2))
    else $error("post divider ratio wrong");

  a_rsvd_reads_zero: assert property (
    psel && !penable |=> prdata[31:7] == 25'h0 ##0 pready)
    else $error("reserved bits not zero");

  a_nv_load_taken: assert property (
    nv_load && !(psel && penable && pwrite) |=>
      first_loop_cap_three_code == $past(nv_cap_three)
      && second_synth_post_div_code == $past(nv_post_div))
    else $error("nonvolatile image not loaded");
endmodule : plf_regs
`default_nettype wire

//--- tb/plf_tb.sv
// Self-checking bench of the loop-filter register slice over APB.
// Assumes plf_regs and plf_cfg.svh on the include path, pclk at 100 MHz.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  typedef struct packed {
    logic [11:0] a;
    logic [7:0] w;
    logic [7:0] r;
    logic [11:0] dec;
  } plf_row_s;
  logic pclk, presetn, psel, penable, pwrite, nv_load, nv_mode_sel, ack_err;
  logic pready, pslverr, first_loop_filter_mode_sel, res_three_known;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] pstrb, post_div_ratio;
  logic [2:0] nv_cap_one, nv_cap_three, nv_post_div, first_loop_cap_one_code;
  logic [2:0] first_loop_cap_three_code, second_synth_post_div_code;
  logic [5:0] nv_res_three, first_loop_res_three_code, cap_three_pf;
  logic [8:0] cap_one_pf;
  logic [10:0] res_three_ohm;
  int error_cnt = 0;
  int samples_checked = 0;
  plf_row_s rows [0:16] = '{
    '{12'h110, 8'h03, 8'h03, 12'h09b}, '{12'h110, 8'hff, 8'h07, 12'h163},
    '{12'h114, 8'h01, 8'h01, 12'h812}, '{12'h114, 8'h04, 8'h04, 12'h93e},
    '{12'h114, 8'h08, 8'h08, 12'ha06}, '{12'h114, 8'h10, 8'h10, 12'hacd},
    '{12'h114, 8'h20, 8'h20, 12'hb56}, '{12'h114, 8'h41, 8'h41, 12'he76},
    '{12'h114, 8'hc0, 8'h40, 12'he76}, '{12'h114, 8'h03, 8'h03, 12'h000},
    '{12'h118, 8'hfd, 8'h05, 12'h019}, '{12'h11c, 8'h14, 8'h14, 12'h006},
    '{12'h118, 8'h07, 8'h07, 12'h023}, '{12'h11c, 8'h04, 8'h04, 12'h002},
    '{12'h11c, 8'h08, 8'h08, 12'h003}, '{12'h11c, 8'h0c, 8'h0c, 12'h004},
    '{12'h11c, 8'he3, 8'h00, 12'h002}};
  plf_regs u_plf_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .nv_load, .nv_cap_one, .nv_res_three, .nv_mode_sel,
    .nv_cap_three, .nv_post_div, .first_loop_cap_one_code, .first_loop_res_three_code,
    .first_loop_filter_mode_sel, .first_loop_cap_three_code, .second_synth_post_div_code,
    .cap_one_pf, .res_three_ohm, .res_three_known, .cap_three_pf, .post_div_ratio);
  always #5 pclk = ~pclk;
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    rd = prdata;
    ack_err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready !== 1'h1) chk("pready", 32'h1, 32'h0);
  endtask : apb
  function automatic logic [11:0] dec_of(input logic [11:0] a);
    case (a)
      12'h110: return {3'h0, cap_one_pf};
      12'h114: return {res_three_known, res_three_ohm};
      12'h118: return {6'h0, cap_three_pf};
      default: return {8'h0, post_div_ratio};
    endcase
  endfunction : dec_of
  task chk_reset;
    logic [7:0] rst_val [0:3];
    rst_val = '{8'h00, 8'h00, 8'h00, 8'h1c};
    for (int i = 0; i < 4; i++) begin
      apb(1'h0, 12'h110 + 12'(4 * i), 8'h00, 4'hf);
      chk("reset read", {24'h0, rst_val[i]}, rd);
    end
    chk("reset decodes", {1'h0, 9'h005, 11'h012, 1'h1, 6'h00, 4'h8}, {1'h0, cap_one_pf,
      res_three_ohm, res_three_known, cap_three_pf, post_div_ratio});
  endtask : chk_reset
  task print_verdict;
    $display("Checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : print_verdict
  initial begin
    #20000;
    error_cnt++;
    print_verdict();
  end
  initial begin
    pclk = 1'h0;
    presetn = 1'h0;
    {psel, penable, pwrite, nv_load, nv_mode_sel} = '0;
    {paddr, pwdata, pstrb, nv_cap_one, nv_res_three, nv_cap_three, nv_post_div} = '0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    chk_reset();
    foreach (rows[i]) begin
      apb(1'h1, rows[i].a, rows[i].w, 4'h1);
      apb(1'h0, rows[i].a, 8'h00, 4'hf);
      chk("slverr", 32'h0, {31'h0, ack_err});
      chk("readback", {24'h0, rows[i].r}, rd);
      chk("decode", {20'h0, rows[i].dec}, {20'h0, dec_of(rows[i].a)});
    end
    // Strobe off, then unmapped places
    apb(1'h1, 12'h110, 8'h01, 4'he);
    apb(1'h0, 12'h110, 8'h00, 4'hf);
    chk("masked write", 32'h7, rd);
    apb(1'h0, 12'h120, 8'h00, 4'hf);
    chk("unmapped read", 32'h1, {rd[30:0], ack_err});
    apb(1'h1, 12'h10c, 8'hff, 4'hf);
    chk("unmapped write", 32'h1, {31'h0, ack_err});
    // Nonvolatile image load
    @(posedge pclk);
    nv_cap_one <= 3'h6;
    nv_res_three <= 6'h20;
    nv_mode_sel <= 1'h1;
    nv_cap_three <= 3'h4;
    nv_post_div <= 3'h3;
    nv_load <= 1'h1;
    @(posedge pclk);
    nv_load <= 1'h0;
    @(posedge pclk);
    #1;
    chk("nv codes", 32'hd063, {16'h0, first_loop_cap_one_code, first_loop_res_three_code,
      first_loop_filter_mode_sel, first_loop_cap_three_code, second_synth_post_div_code});
    apb(1'h0, 12'h114, 8'h00, 4'hf);
    chk("nv readback", 32'h41, rd);
    // Reset in mid-run
    @(posedge pclk);
    presetn <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    chk_reset();
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
